// ### hw/icc_input_capture_channel.sv
/*
 * One input capture channel: edge detect with prescaler, timer selection,
 * capture FIFO, overflow and buffer status, captures-per-interrupt counter
 * and a sticky, maskable interrupt register set.
 * Register indices: control, capture result, interrupt status, interrupt mask.
 * Interrupt bits: capture count reached, capture dropped on overflow, wake edge.
 * A result read on an empty FIFO returns a stale entry and pops nothing.
 * Any control write restarts the prescaler and the captures-per-interrupt count.
 * A capture lands about three cycles after the pin moves, set by the synchroniser.
 * Pin pulses shorter than two cycles may be lost; that is the price of the filter.
 * The interrupt output is registered yet rises with the status bit behind it.
 * Assumes the capture pin is asynchronous to ref_clk, the timer counts and
 * the power-mode levels come from logic on ref_clk.
 */
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ns

module icc_input_capture_channel #(
    parameter int DATA_W = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire icc_pkg::icc_bus_s bus,
    output logic [15:0] rdata,
    // Capture pin and timer sources
    input wire logic capture_pin,
    input wire logic [DATA_W-1:0] second_timer_count,
    input wire logic [DATA_W-1:0] third_timer_count,
    // Device power state
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    // Interrupt
    output logic irq
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    // Decode of a control word into fields, used for the stored copy
    function automatic icc_pkg::icc_ctrl_s decode_ctrl(input logic [15:0] w);
        icc_pkg::icc_ctrl_s c;
        c.idle_stop_control = w[icc_pkg::IDLE_STOP_BIT];
        c.capture_timer_select = w[icc_pkg::TIMER_SEL_BIT];
        c.captures_per_interrupt = w[icc_pkg::CPI_HI:icc_pkg::CPI_LO];
        c.capture_mode_field = w[icc_pkg::MODE_HI:icc_pkg::MODE_LO];
        return c;
    endfunction : decode_ctrl

    // Strobe qualified by a register index, shared by the write decodes and the result-read pop
    function automatic logic reg_hit(input logic stb, input logic [2:0] a, input logic [2:0] idx);
        return stb && (a == idx);
    endfunction : reg_hit

    // Ring increment shared by both FIFO pointers; DEPTH need not be a power of two
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (32'(p) == DEPTH - 1) ? '0 : p + PTR_W'(1);
    endfunction : ptr_inc

    // Control word as software last wrote it
    logic [15:0] control;

    // Synchroniser stages and the settled pin level
    logic [2:0] pin_sync;
    logic pin_last;

    // Prescaler and captures-per-interrupt counters
    logic [3:0] prescale;
    logic [1:0] cpi_count;

    // Capture FIFO, addressed by index
    logic [DATA_W-1:0] fifo_mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] fill;

    // Overflow flag and interrupt registers
    logic overflow;
    logic [icc_pkg::NUM_EVENTS-1:0] int_status;
    logic [icc_pkg::NUM_EVENTS-1:0] int_mask;

    // Decoded control fields
    icc_pkg::icc_ctrl_s ctrl;
    assign ctrl = decode_ctrl(control);

    // Pin is seen as changed only once the second and third stages agree
    // so a glitch caught by one stage alone never makes an edge
    wire pin_stable = (pin_sync[1] == pin_sync[2]);
    wire pin_now = pin_stable ? pin_sync[2] : pin_last;
    wire rise = pin_now & ~pin_last;
    wire fall = ~pin_now & pin_last;

    wire halted = ctrl.idle_stop_control & cpu_idle;
    wire [2:0] mode = ctrl.capture_mode_field;
    wire cap_mode = (mode != icc_pkg::MODE_OFF) && (mode != icc_pkg::MODE_UNUSED)
                    && (mode != icc_pkg::MODE_WAKE);
    wire run = cap_mode & ~halted;

    // Mode codes looked at by the edge-select, count and wake paths
    wire mode_every = (mode == icc_pkg::MODE_EVERY_EDGE);
    wire mode_fall = (mode == icc_pkg::MODE_FALL);
    wire mode_wake = (mode == icc_pkg::MODE_WAKE);

    wire edge_hit = mode_every ? (rise | fall) : mode_fall ? fall : rise;
    wire [3:0] pre_last = (mode == icc_pkg::MODE_RISE16) ? icc_pkg::PRESCALE_16_LAST :
                          icc_pkg::PRESCALE_4_LAST;
    wire pre_mode = (mode == icc_pkg::MODE_RISE4) || (mode == icc_pkg::MODE_RISE16);
    wire capture = run & edge_hit & (~pre_mode | (prescale == pre_last));

    // wake interrupt from rising edges while asleep or idle
    wire wake_evt = mode_wake & rise & (cpu_sleep | cpu_idle);

    wire [DATA_W-1:0] cap_value = ctrl.capture_timer_select ? second_timer_count
                                                             : third_timer_count;

    // FIFO level; fill counts up to DEPTH so full and empty never alias
    wire full = (fill == CNT_W'(DEPTH));
    wire empty = (fill == '0);
    wire push = capture & ~full;
    // a result read pops the oldest entry unless the FIFO is empty
    wire rd_result = reg_hit(bus.rd, bus.addr, icc_pkg::ADDR_RESULT);
    wire pop = rd_result & ~empty;

    // captures-per-interrupt count, bypassed in every-edge mode
    wire cpi_done = mode_every || (cpi_count == ctrl.captures_per_interrupt);
    wire cap_int = capture & cpi_done;

    // Register write decode
    wire wr_ctrl = reg_hit(bus.wr, bus.addr, icc_pkg::ADDR_CONTROL);
    wire wr_stat = reg_hit(bus.wr, bus.addr, icc_pkg::ADDR_INT_STATUS);
    wire wr_mask = reg_hit(bus.wr, bus.addr, icc_pkg::ADDR_INT_MASK);

    // next control word keeps only the implemented bits
    wire [15:0] next_control = wr_ctrl ? (bus.wdata & icc_pkg::CONTROL_WMASK) : control;

    // next prescale; a control write restarts it so no stale count survives
    wire [3:0] next_prescale = (!run || !pre_mode || wr_ctrl) ? 4'h0 :
                               !rise ? prescale :
                               (prescale == pre_last) ? 4'h0 : prescale + 4'h1;

    // next capture count, restarted on a control write or outside the capture modes, held while halted
    wire [1:0] next_cpi_count = (!cap_mode || wr_ctrl) ? 2'h0 :
                                !capture ? cpi_count :
                                cpi_done ? 2'h0 : cpi_count + 2'h1;

    wire [PTR_W-1:0] next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
    wire [PTR_W-1:0] next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
    wire [CNT_W-1:0] next_fill = fill + CNT_W'(push) - CNT_W'(pop);

    // Interrupt events: wake edge, dropped capture, captures-per-interrupt reached
    wire [icc_pkg::NUM_EVENTS-1:0] events = {wake_evt, capture & full, cap_int};
    // Write-one-to-clear bits, zero unless software writes the status index
    wire [icc_pkg::NUM_EVENTS-1:0] clear_bits =
        wr_stat ? bus.wdata[icc_pkg::NUM_EVENTS-1:0] : '0;
    // A new event wins over a clear that lands in the same cycle
    wire [icc_pkg::NUM_EVENTS-1:0] next_int_status = (int_status & ~clear_bits) | events;
    wire [icc_pkg::NUM_EVENTS-1:0] next_int_mask =
        wr_mask ? bus.wdata[icc_pkg::NUM_EVENTS-1:0] : int_mask;

    // status bits shown in the control word
    logic [15:0] ctrl_view;
    always_comb begin
        ctrl_view = control;
        ctrl_view[icc_pkg::OVF_BIT] = overflow;
        ctrl_view[icc_pkg::BNE_BIT] = ~empty;
    end

    // Read data mux; unmapped addresses read zero
    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = 16'h0000;
        case (bus.addr)
            icc_pkg::ADDR_CONTROL: next_rdata = ctrl_view;
            icc_pkg::ADDR_RESULT: next_rdata = 16'(fifo_mem[rd_ptr]);
            icc_pkg::ADDR_INT_STATUS: next_rdata = 16'(int_status);
            icc_pkg::ADDR_INT_MASK: next_rdata = 16'(int_mask);
            default: next_rdata = 16'h0000;
        endcase
    end

    // Pin synchroniser and settled edge reference
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_sync <= 3'h0;
            pin_last <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], capture_pin};
            pin_last <= pin_now;
        end
    end

    // Control register; only implemented bits take writes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            control <= icc_pkg::CONTROL_RESET;
        end else begin
            control <= next_control;
        end
    end

    // prescaler counts intermediate edges; cleared when leaving run
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prescale <= 4'h0;
        end else begin
            prescale <= next_prescale;
        end
    end

    // capture counter toward the next interrupt
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cpi_count <= 2'h0;
        end else begin
            cpi_count <= next_cpi_count;
        end
    end

    // FIFO storage written by index
    // No reset: an empty-FIFO read shows whatever the slot last held
    always_ff @(posedge ref_clk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= cap_value;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            fill <= next_fill;
        end
    end

    // overflow sets on a capture into a full FIFO, clears once emptied
    // The set never meets the clear: a full FIFO is never empty
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            overflow <= 1'b0;
        end else if (capture && full) begin
            overflow <= 1'b1;
        end else if (empty) begin
            overflow <= 1'b0;
        end
    end

    // Sticky status, write-one-to-clear, a new event wins over the clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            int_status <= '0;
            int_mask <= '0;
        end else begin
            int_status <= next_int_status;
            int_mask <= next_int_mask;
        end
    end

    // Read data registered, valid only the cycle after the strobe
    // and zero otherwise, so no stale value lingers on the port
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= bus.rd ? next_rdata : 16'h0000;
        end
    end

    // Level interrupt while any unmasked status bit is set; built from the next
    // values so the flip-flop rises in the same cycle as the status bit
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_int_status & next_int_mask);
        end
    end

endmodule : icc_input_capture_channel

// ### hw/icc_pkg.sv
/*
 * Package for the input capture channel: register map, field positions,
 * mode codes and shared carrier types.
 * Assumes a 16-bit register port and two 16-bit timer counts from outside.
 */
package icc_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_RESULT = 3'h1;
    localparam logic [2:0] ADDR_INT_STATUS = 3'h2;
    localparam logic [2:0] ADDR_INT_MASK = 3'h3;

    // Control register field positions
    localparam int IDLE_STOP_BIT = 13;
    localparam int TIMER_SEL_BIT = 7;
    localparam int CPI_HI = 6;
    localparam int CPI_LO = 5;
    localparam int OVF_BIT = 4;
    localparam int BNE_BIT = 3;
    localparam int MODE_HI = 2;
    localparam int MODE_LO = 0;

    // Reset values and writable-bit mask of the control register
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_WMASK = 16'h20e7;

    // Interrupt status bit positions
    localparam int EVT_CAPTURE = 0;
    localparam int EVT_OVERFLOW = 1;
    localparam int EVT_WAKE = 2;
    localparam int NUM_EVENTS = 3;

    // Mode field codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_EVERY_EDGE = 3'h1;
    localparam logic [2:0] MODE_FALL = 3'h2;
    localparam logic [2:0] MODE_RISE = 3'h3;
    localparam logic [2:0] MODE_RISE4 = 3'h4;
    localparam logic [2:0] MODE_RISE16 = 3'h5;
    localparam logic [2:0] MODE_UNUSED = 3'h6;
    localparam logic [2:0] MODE_WAKE = 3'h7;

    // Prescale terminal counts for the divided rising-edge modes
    localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hf;

    // Software side of the register port
    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } icc_bus_s;

    // Decoded control fields
    typedef struct packed {
        logic idle_stop_control;
        logic capture_timer_select;
        logic [1:0] captures_per_interrupt;
        logic [2:0] capture_mode_field;
    } icc_ctrl_s;

endpackage : icc_pkg

// ### sim/icc_input_capture_channel_asserts.sv
/* Checker for the capture channel: read slot, read-back, irq gating.
   Assumes only the top module's ports; bound below. */
`timescale 1ns/1ns
module icc_input_capture_channel_asserts #(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire icc_pkg::icc_bus_s bus,
    input wire logic [15:0] rdata,
    // Pin, timers, power state
    input wire logic capture_pin,
    input wire logic [DATA_W-1:0] second_timer_count,
    input wire logic [DATA_W-1:0] third_timer_count,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    // Interrupt
    input wire logic irq
);
    logic [15:0] ctrl_sh;
    logic [2:0] mask_sh;
    wire wr_ctl = bus.wr && bus.addr == icc_pkg::ADDR_CONTROL;
    wire wr_msk = bus.wr && bus.addr == icc_pkg::ADDR_INT_MASK;
    wire is_off = ctrl_sh[2:0] == icc_pkg::MODE_OFF || ctrl_sh[2:0] == icc_pkg::MODE_UNUSED;

    // Shadow of what software wrote, so read-back can be judged
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_sh <= 16'h0000;
            mask_sh <= 3'h0;
        end else begin
            if (wr_ctl) ctrl_sh <= bus.wdata & icc_pkg::CONTROL_WMASK;
            if (wr_msk) mask_sh <= bus.wdata[2:0];
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_RDATA_IDLE:
        assert property (!$past(bus.rd) |-> rdata == 16'h0000) else $error("rdata outside slot");
    AST_CTRL_RSVD:
        assert property ($past(bus.rd) && $past(bus.addr) == icc_pkg::ADDR_CONTROL
            |-> rdata[15:14] == 2'h0 && rdata[12:8] == 5'h00) else $error("reserved bits set");
    AST_CTRL_RB:
        assert property ($past(bus.rd) && $past(bus.addr) == icc_pkg::ADDR_CONTROL
            |-> (rdata & icc_pkg::CONTROL_WMASK) == ctrl_sh) else $error("control read-back");
    AST_UNMAPPED:
        assert property ($past(bus.rd) && $past(bus.addr) > 3'h3 |-> rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_MASK_RB:
        assert property ($past(bus.rd) && $past(bus.addr) == icc_pkg::ADDR_INT_MASK
            |-> rdata == {13'h0000, mask_sh}) else $error("mask read-back");
    AST_IRQ_MASKED:
        assert property (irq |-> mask_sh != 3'h0) else $error("irq with all masked");
    AST_CLEAR_OFF:
        assert property (bus.wr && bus.addr == icc_pkg::ADDR_INT_STATUS
            && bus.wdata[2:0] == 3'h7 && is_off ##1 1'b1 |-> !irq) else $error("irq after clear");
    AST_OFF_QUIET:
        assert property (!irq && is_off && !bus.wr |=> !irq) else $error("irq while off");

    cover property (wr_ctl && bus.wdata[2:0] == icc_pkg::MODE_RISE16);
    cover property ($rose(irq));
    cover property ($past(bus.rd) && $past(bus.addr) == icc_pkg::ADDR_RESULT && rdata != 0);
endmodule : icc_input_capture_channel_asserts

bind icc_input_capture_channel icc_input_capture_channel_asserts #(.DATA_W(DATA_W)) u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .capture_pin(capture_pin),
    .second_timer_count(second_timer_count), .third_timer_count(third_timer_count),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));

// ### sim/icc_input_capture_channel_tb.sv
/* Self-checking bench for the capture channel.
   Assumes the pin model on the capture input and a depth-4 FIFO. */
`timescale 1ns/1ns
module icc_input_capture_channel_tb;
    localparam int DEPTH = 4;
    localparam logic [2:0] CA = icc_pkg::ADDR_CONTROL;
    localparam logic [2:0] RA = icc_pkg::ADDR_RESULT;
    localparam logic [2:0] SA = icc_pkg::ADDR_INT_STATUS;
    localparam logic [2:0] MA = icc_pkg::ADDR_INT_MASK;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    icc_pkg::icc_bus_s bus = '0;
    logic [15:0] rdata;
    logic capture_pin;
    logic [15:0] t2 = 16'h0000;
    logic [15:0] t3 = 16'h0000;
    logic cpu_idle = 1'b0;
    logic cpu_sleep = 1'b0;
    logic irq;
    int error_cnt = 0;
    int cmp_count = 0;

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    icc_input_capture_channel #(.DEPTH(DEPTH)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
        .bus(bus), .rdata(rdata), .capture_pin(capture_pin), .second_timer_count(t2),
        .third_timer_count(t3), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));
    icc_pin_model u_pin (.ref_clk(ref_clk), .pin(capture_pin));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Bus cycles: strobe for one edge, released right after it
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd

    task automatic t_regs;
        rd(CA, 16'h0000);
        wr(CA, 16'hfff8);
        rd(CA, 16'h20e0);
        rd(3'h5, 16'h0000);
        wr(MA, 16'h0001);
        rd(MA, 16'h0001);
        wr(CA, 16'h0000);
        $display("registers done");
    endtask : t_regs

    // Program a mode, pulse the pin, then judge flags and drain the FIFO
    task automatic run(input logic [15:0] ctl, input int n, input int caps);
        logic [15:0] v;
        v = ctl[7] ? {8'h2a, ctl[7:0]} : {8'h3b, ctl[7:0]};
        wr(CA, ctl);
        t2 <= {8'h2a, ctl[7:0]};
        t3 <= {8'h3b, ctl[7:0]};
        u_pin.pulses(n);
        repeat (8) @(posedge ref_clk);
        rd(CA, ctl | (caps > 0 ? 16'h0008 : 16'h0) | (caps > DEPTH ? 16'h0010 : 16'h0));
        repeat (caps > DEPTH ? DEPTH : caps) rd(RA, v);
        rd(CA, ctl);
        rd(SA, {14'h0000, caps > DEPTH, caps > 0});
        wr(CA, 16'h0000);
        wr(SA, 16'h0007);
        $display("mode run %h done", ctl);
    endtask : run

    // Interrupt after c+1 captures, and every-edge mode ignoring the count
    task automatic t_cpi;
        for (int c = 0; c < 4; c++) begin
            wr(CA, 16'(c * 32 + 3));
            u_pin.pulses(c);
            repeat (8) @(posedge ref_clk);
            #1 chk(16'(irq), 16'h0000);
            u_pin.pulses(1);
            repeat (8) @(posedge ref_clk);
            #1 chk(16'(irq), 16'h0001);
            repeat (c + 1) rd(RA, 16'h3b03);
            wr(CA, 16'h0000);
            wr(SA, 16'h0007);
            #1 chk(16'(irq), 16'h0000);
        end
        wr(CA, 16'h0061);
        u_pin.pulses(1);
        repeat (8) @(posedge ref_clk);
        #1 chk(16'(irq), 16'h0001);
        repeat (2) rd(RA, 16'h3b03);
        wr(CA, 16'h0000);
        wr(SA, 16'h0007);
        $display("interrupt count done");
    endtask : t_cpi

    task automatic t_wake;
        wr(MA, 16'h0004);
        wr(CA, 16'h0007);
        cpu_sleep <= 1'b1;
        u_pin.pulses(1);
        repeat (8) @(posedge ref_clk);
        rd(SA, 16'h0004);
        rd(CA, 16'h0007);
        chk(16'(irq), 16'h0001);
        wr(SA, 16'h0004);
        #1 chk(16'(irq), 16'h0000);
        cpu_sleep <= 1'b0;
        wr(CA, 16'h0000);
        $display("wake done");
    endtask : t_wake

    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        run(16'h0083, 2, 2);
        run(16'h0002, 2, 2);
        run(16'h0001, 2, 4);
        run(16'h0004, 8, 2);
        run(16'h0005, 16, 1);
        run(16'h0000, 2, 0);
        run(16'h0006, 2, 0);
        run(16'h0003, 5, 5);
        cpu_idle <= 1'b1;
        run(16'h2003, 1, 0);
        run(16'h0003, 1, 1);
        cpu_idle <= 1'b0;
        t_cpi();
        t_wake();
        stop_test();
    end

    // Hang guard, well beyond the fewer than a thousand cycles the tests take
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        stop_test();
    end
endmodule : icc_input_capture_channel_tb

// ### sim/icc_pin_model.sv
/* Far-side source for the capture pin: clean pulses on demand.
   Assumes ref_clk from the bench; the pin rests low between pulses. */
`timescale 1ns/1ns
module icc_pin_model (
    // Clock
    input wire logic ref_clk,
    // Capture pin drive
    output logic pin
);
    initial pin = 1'b0;

    // Edges four cycles apart, wider than the synchroniser, so none merge
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            pin <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask : pulses
endmodule : icc_pin_model
